// ===== rts_pkg.sv
// Purpose: Shared constants for the reset and time-out sequencer.
// Assumes: Core clock of 100 MHz; the delay time base is derived from it.
// Notes: Register offsets index a small plain-port register file.
package rts_pkg;
  localparam int CLK_MHZ = 100;
  localparam int POWER_UP_DELAY_TIMER_MS = 72;
  localparam int POWER_UP_DELAY_TIMER_CYCLES = POWER_UP_DELAY_TIMER_MS * 1000 * CLK_MHZ;
  localparam int OST_COUNT = 1024;
  localparam int OST_W = 11;
  localparam int FILT_CYCLES = 4;
  localparam int FILT_W = 3;
  localparam logic [1:0] OSC_LP = 2'h0;
  localparam logic [1:0] OSC_XT = 2'h1;
  localparam logic [1:0] OSC_HS = 2'h2;
  localparam logic [1:0] OSC_RC = 2'h3;
  localparam logic [3:0] OFF_POWER_STATUS = 4'h0;
  localparam logic [3:0] OFF_CAUSE = 4'h1;
  localparam logic [3:0] OFF_CONFIG = 4'h2;
  localparam logic [3:0] OFF_RETAIN = 4'h3;
  localparam int PS_BOR_BIT = 0;
  localparam int PS_POR_BIT = 1;
  localparam logic [12:0] VEC_RESET = 13'h0000;
  localparam logic [12:0] VEC_IRQ = 13'h0004;
  typedef enum logic [1:0] {
    RTS_ST_HOLD = 2'b00,
    RTS_ST_POWER_UP_DELAY_TIMER = 2'b01,
    RTS_ST_OST = 2'b10,
    RTS_ST_RUN = 2'b11
  } rts_state_e;
endpackage

// ===== rts_pin_filter.sv
// Purpose: Glitch filter on the external reset pin.
// Assumes: Pin is synchronous to the clock.
// Notes: A level must hold for FILT_CYCLES before it is accepted.
`timescale 1ns/1ns
module rts_pin_filter (
  input wire logic clock,
  input wire logic arst_n,
  input wire logic pin_n,
  output logic filt_n
);
  logic [rts_pkg::FILT_W-1:0] cnt_r;
  logic filt_r;
  wire differs = pin_n != filt_r;
  wire done = cnt_r == rts_pkg::FILT_W'(rts_pkg::FILT_CYCLES - 1);

  // Short pulses restart the count and never reach the output.
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      cnt_r <= '0;
      filt_r <= 1'b1;
    end else if (!differs) begin
      cnt_r <= '0;
    end else if (done) begin
      cnt_r <= '0;
      filt_r <= pin_n;
    end else begin
      cnt_r <= cnt_r + 1'b1;
    end
  end
  assign filt_n = filt_r;
endmodule

// ===== rts_retain_mem.sv
// Purpose: Small storage with no reset, kept across every reset type.
// Assumes: Contents are unknown after power-on.
// Notes: Read data come from a register.
`timescale 1ns/1ns
module rts_retain_mem (
  input wire logic clock,
  input wire logic we,
  input wire logic [1:0] addr,
  input wire logic [7:0] wdata,
  output logic [7:0] rdata
);
  logic [7:0] mem_r [4];
  // No reset on purpose: values survive all reset sources.
  always_ff @(posedge clock) begin
    if (we) begin
      mem_r[addr] <= wdata;
    end
    rdata <= mem_r[addr];
  end
endmodule

// ===== rts_sequencer.sv
// Purpose: Merge reset sources, run power-up and oscillator time-outs, keep cause flags.
// Assumes: All inputs synchronous to clock; arst_n is the power-on pulse.
// Notes: The oscillator input is sampled and counted on its rising edges.
// Behaviour
// RQ1: Power-up delay 72 ms holds reset.
// RQ2: Config bit gates delay; delay then oscillator count.
// RQ3: Delay enable bit is active low.
// RQ4: Oscillator count holds 1024 input cycles.
// RQ5: Oscillator count: crystal modes, power-on or wake.
// RQ6: Resistor mode, delay off: no time-out.
// RQ7: Brown-out logic follows its enable bit.
// RQ8: Brown-out holds reset, then 72 ms delay.
// RQ9: Brown-out during delay restarts the delay.
// RQ10: Brown-out enable forces the delay on.
// RQ11: Software should keep delay on with brown-out.
// RQ12: Time-outs ignore pin; late pin rise runs.
// RQ13: Reset pin is noise filtered.
// RQ14: Watchdog never drives the reset pin.
// RQ15: Defined registers load on resets, not wake.
// RQ16: Status flags follow the reset cause.
// RQ17: Power status bit0 is brown-out flag.
// RQ18: Power status bit1 is power-on flag.
// RQ19: Restart vector 000h, wake next, irq 0004h.
// RQ20: Some registers survive every reset.
// RQ21: All sources merge into one reset.
`timescale 1ns/1ns
module rts_sequencer #(
  parameter int POWER_UP_DELAY_TIMER_CYCLES = rts_pkg::POWER_UP_DELAY_TIMER_CYCLES
) (
  input wire logic clock,
  input wire logic arst_n,
  input wire logic external_reset_pin_n,
  input wire logic oscillator_input_pin,
  input wire logic brown_out_low,
  input wire logic watchdog_timeout,
  input wire logic sleeping,
  input wire logic wake_irq,
  input wire logic global_irq_enable,
  input wire logic brown_out_enable,
  input wire logic power_up_delay_enable,
  input wire logic [1:0] osc_select,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  output logic external_reset_pin_oe,
  output logic core_reset_n,
  output logic regs_load,
  output logic pc_load,
  output logic pc_next,
  output logic [12:0] pc_vector,
  output logic watchdog_expired_n,
  output logic sleep_entered_n
);
  localparam int PW = $clog2(POWER_UP_DELAY_TIMER_CYCLES + 1);

  rts_pkg::rts_state_e state_r, state_nxt;
  logic [PW-1:0] power_up_delay_timer_cnt_r;
  logic [rts_pkg::OST_W-1:0] ost_cnt_r;
  logic osc_q_r;
  logic ost_req_r;
  logic [7:0] power_status_r;
  logic to_n_r, pd_n_r;
  logic run_q_r;
  logic [7:0] mem_rdata;
  logic rd_mem_r;
  logic [7:0] rdata_r;
  logic [3:0] cause_r;
  logic pin_filt_n;

  // Filtered pin.
  // RQ13: noise filter instance.
  rts_pin_filter u_filt (
    .clock(clock),
    .arst_n(arst_n),
    .pin_n(external_reset_pin_n),
    .filt_n(pin_filt_n)
  );

  // RQ14: pin stays input
  assign external_reset_pin_oe = 1'b0;

  // RQ7: brown-out gated by enable
  wire bor_active = brown_out_enable & brown_out_low;
  // RQ3: active-low delay enable
  // RQ10: brown-out forces delay
  wire power_up_delay_timer_on = ~power_up_delay_enable | brown_out_enable;
  // RQ5: crystal modes only
  wire crystal = osc_select != rts_pkg::OSC_RC;
  wire osc_rise = oscillator_input_pin & ~osc_q_r;
  wire power_up_delay_timer_done = power_up_delay_timer_cnt_r == PW'(POWER_UP_DELAY_TIMER_CYCLES - 1);
  wire ost_done = ost_cnt_r == rts_pkg::OST_W'(rts_pkg::OST_COUNT - 1);
  wire wake_ev = sleeping & (watchdog_timeout | wake_irq);
  wire wdt_reset = watchdog_timeout & ~sleeping;
  wire pin_reset = ~pin_filt_n;
  wire run = state_r == rts_pkg::RTS_ST_RUN;

  // Time-out sequencer; the pin does not stall it.
  // RQ2: delay first, then count
  // RQ6: no time-out path
  // RQ12: independent of pin
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      rts_pkg::RTS_ST_HOLD: begin
        if (power_up_delay_timer_on) begin
          state_nxt = rts_pkg::RTS_ST_POWER_UP_DELAY_TIMER;
        end else if (crystal && ost_req_r) begin
          state_nxt = rts_pkg::RTS_ST_OST;
        end else begin
          state_nxt = rts_pkg::RTS_ST_RUN;
        end
      end
      rts_pkg::RTS_ST_POWER_UP_DELAY_TIMER: begin
        if (power_up_delay_timer_done) begin
          state_nxt = (crystal && ost_req_r) ? rts_pkg::RTS_ST_OST : rts_pkg::RTS_ST_RUN;
        end
      end
      rts_pkg::RTS_ST_OST: begin
        if (ost_done && osc_rise) begin
          state_nxt = rts_pkg::RTS_ST_RUN;
        end
      end
      rts_pkg::RTS_ST_RUN: begin
        if (wake_ev && crystal) begin
          state_nxt = rts_pkg::RTS_ST_OST;
        end
      end
      default: state_nxt = rts_pkg::RTS_ST_HOLD;
    endcase
    // RQ8: brown-out holds reset
    // RQ9: brown-out restarts delay
    if (bor_active) begin
      state_nxt = rts_pkg::RTS_ST_HOLD;
    end
  end

  // State and counters.
  // RQ1: 72 ms delay count
  // RQ4: 1024 oscillator edges
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      state_r <= rts_pkg::RTS_ST_HOLD;
      power_up_delay_timer_cnt_r <= '0;
      ost_cnt_r <= '0;
      osc_q_r <= 1'b0;
      ost_req_r <= 1'b1;
    end else begin
      state_r <= state_nxt;
      osc_q_r <= oscillator_input_pin;
      power_up_delay_timer_cnt_r <= (state_r == rts_pkg::RTS_ST_POWER_UP_DELAY_TIMER && !bor_active) ?
                    power_up_delay_timer_cnt_r + 1'b1 : '0;
      if (state_r != rts_pkg::RTS_ST_OST) begin
        ost_cnt_r <= '0;
      end else if (osc_rise) begin
        ost_cnt_r <= ost_cnt_r + 1'b1;
      end
      // Brown-out restarts without the oscillator count.
      if (bor_active) begin
        ost_req_r <= 1'b0;
      end
    end
  end

  // Merged core reset, released only when every source is idle.
  // RQ21: single merged reset
  wire reset_any = !run || pin_reset || wdt_reset || bor_active;
  wire in_wake_ost = state_r == rts_pkg::RTS_ST_OST && run_q_r;
  wire hold = reset_any && !in_wake_ost;

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      core_reset_n <= 1'b0;
      run_q_r <= 1'b0;
    end else begin
      core_reset_n <= !hold && !in_wake_ost;
      if (hold) begin
        run_q_r <= 1'b0;
      end else if (run) begin
        run_q_r <= 1'b1;
      end
    end
  end

  // Cause record and status flags.
  // RQ16: flag update per cause
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      to_n_r <= 1'b1;
      pd_n_r <= 1'b1;
      cause_r <= 4'h1;
    end else if (bor_active) begin
      to_n_r <= 1'b1;
      pd_n_r <= 1'b1;
      cause_r <= 4'h2;
    end else if (wdt_reset) begin
      to_n_r <= 1'b0;
      pd_n_r <= 1'b1;
      cause_r <= 4'h3;
    end else if (sleeping && watchdog_timeout) begin
      to_n_r <= 1'b0;
      pd_n_r <= 1'b0;
      cause_r <= 4'h4;
    end else if (sleeping && (pin_reset || wake_irq)) begin
      to_n_r <= 1'b1;
      pd_n_r <= 1'b0;
      cause_r <= pin_reset ? 4'h5 : 4'h6;
    end else if (pin_reset) begin
      cause_r <= 4'h7;
    end
  end
  assign watchdog_expired_n = to_n_r;
  assign sleep_entered_n = pd_n_r;

  // Restart control: resets reload registers and vector, wakes continue unless an enabled irq loads the irq vector.
  // A reset in the same cycle as a wake outranks it, so the vector stays at zero.
  wire irq_jump = wake_ev && wake_irq && global_irq_enable && !hold;
  // RQ15: load on resets only
  // RQ19: vector selection
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      regs_load <= 1'b1;
      pc_load <= 1'b1;
      pc_next <= 1'b0;
      pc_vector <= rts_pkg::VEC_RESET;
    end else begin
      regs_load <= hold;
      pc_load <= hold || irq_jump;
      pc_next <= wake_ev && !hold && !irq_jump;
      pc_vector <= irq_jump ? rts_pkg::VEC_IRQ : rts_pkg::VEC_RESET;
    end
  end

  // Power status: hardware clear wins over software set.
  // RQ17: brown-out flag
  // RQ18: power-on flag
  wire ps_wr = reg_wr && reg_addr == rts_pkg::OFF_POWER_STATUS;
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      power_status_r <= 8'h00;
    end else begin
      if (ps_wr) begin
        power_status_r <= {6'h00, reg_wdata[1:0]};
      end
      if (bor_active) begin
        power_status_r[rts_pkg::PS_BOR_BIT] <= 1'b0;
      end
    end
  end

  // RQ20: retained storage
  rts_retain_mem u_mem (
    .clock(clock),
    .we(reg_wr && reg_addr[3:2] == 2'h1),
    .addr(reg_addr[1:0]),
    .wdata(reg_wdata),
    .rdata(mem_rdata)
  );

  // Read port: data the cycle after the strobe; unmapped reads zero.
  wire [7:0] cfg_view = {3'h0, brown_out_enable, power_up_delay_enable, crystal, osc_select};
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      rdata_r <= 8'h00;
      rd_mem_r <= 1'b0;
    end else begin
      rd_mem_r <= reg_rd && reg_addr[3:2] == 2'h1;
      case (reg_addr)
        rts_pkg::OFF_POWER_STATUS: rdata_r <= power_status_r;
        rts_pkg::OFF_CAUSE: rdata_r <= {4'h0, cause_r};
        rts_pkg::OFF_CONFIG: rdata_r <= cfg_view;
        rts_pkg::OFF_RETAIN: rdata_r <= {6'h00, state_r};
        default: rdata_r <= 8'h00;
      endcase
    end
  end
  assign reg_rdata = rd_mem_r ? mem_rdata : rdata_r;
endmodule

// ===== rts_partner.sv
// Purpose: Far side of the sequencer: crystal and supply detector.
// Assumes: Crystal runs at a quarter of the core clock.
// Notes: Detector output lags the supply by one cycle.
`timescale 1ns/1ns
module rts_partner (
  input wire logic clock,
  input wire logic supply_low,
  output logic oscillator_input_pin,
  output logic brown_out_low
);
  logic [1:0] div_r = 2'h0;
  // A slow crystal keeps every rising edge visible to the sampling core.
  always_ff @(posedge clock) begin
    div_r <= div_r + 2'h1;
    brown_out_low <= supply_low;
  end
  assign oscillator_input_pin = div_r[1];
endmodule

// ===== rts_sequencer_asserts.sv
// Purpose: Port checks for the reset sequencer.
// Assumes: Configuration inputs hold still between power-ons.
// Notes: Bound to every instance below.
`timescale 1ns/1ns
module rts_sequencer_asserts #(
  parameter int POWER_UP_DELAY_TIMER_CYCLES = rts_pkg::POWER_UP_DELAY_TIMER_CYCLES
) (
  input wire logic clock,
  input wire logic arst_n,
  input wire logic external_reset_pin_n,
  input wire logic brown_out_low,
  input wire logic watchdog_timeout,
  input wire logic sleeping,
  input wire logic brown_out_enable,
  input wire logic power_up_delay_enable,
  input wire logic [1:0] osc_select,
  input wire logic external_reset_pin_oe,
  input wire logic core_reset_n,
  input wire logic regs_load,
  input wire logic [12:0] pc_vector,
  input wire logic watchdog_expired_n,
  input wire logic sleep_entered_n
);
  default clocking @(posedge clock); endclocking
  default disable iff (!arst_n);
  int up_cnt;
  // Saturates so a long run never wraps back into the delay window.
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) up_cnt <= 0;
    else if (up_cnt < POWER_UP_DELAY_TIMER_CYCLES) up_cnt <= up_cnt + 1;
  end
  pin_input_a: assert property (!external_reset_pin_oe)
    else $error("reset pin driven");
  delay_hold_a: assert property (up_cnt < POWER_UP_DELAY_TIMER_CYCLES
    && (!power_up_delay_enable || brown_out_enable) |-> !core_reset_n)
    else $error("core released inside delay");
  rc_fast_a: assert property ($rose(arst_n) && osc_select == rts_pkg::OSC_RC
    && power_up_delay_enable && !brown_out_enable && external_reset_pin_n
    |-> ##[1:10] core_reset_n) else $error("rc start delayed");
  bor_hold_a: assert property (brown_out_enable && brown_out_low [*3] |-> !core_reset_n)
    else $error("core ran in brown-out");
  bor_off_a: assert property (!brown_out_enable && brown_out_low && core_reset_n
    && external_reset_pin_n && !watchdog_timeout |=> core_reset_n)
    else $error("disabled brown-out reset the core");
  glitch_a: assert property (core_reset_n && $fell(external_reset_pin_n)
    ##1 external_reset_pin_n |-> core_reset_n [*4]) else $error("glitch reset core");
  reset_vec_a: assert property (regs_load |-> pc_vector == rts_pkg::VEC_RESET)
    else $error("reset vector wrong");
  wdt_flags_a: assert property (core_reset_n && watchdog_timeout && !sleeping
    |-> ##[1:3] (!watchdog_expired_n && sleep_entered_n)) else $error("watchdog flags");
  cover property ($rose(core_reset_n));
  cover property (pc_vector == rts_pkg::VEC_IRQ);
  cover property (brown_out_enable && brown_out_low ##1 !brown_out_low);
endmodule
bind rts_sequencer rts_sequencer_asserts #(.POWER_UP_DELAY_TIMER_CYCLES(POWER_UP_DELAY_TIMER_CYCLES)) chk (.clock, .arst_n,
  .external_reset_pin_n, .brown_out_low, .watchdog_timeout, .sleeping, .brown_out_enable,
  .power_up_delay_enable, .osc_select, .external_reset_pin_oe, .core_reset_n, .regs_load,
  .pc_vector, .watchdog_expired_n, .sleep_entered_n);

// ===== tb_top.sv
// Purpose: Self-checking bench for the reset sequencer.
// Assumes: Delay shortened to POWER_UP_DELAY_TIMER cycles; crystal at a quarter clock.
// Notes: Register reads are scored from a queue of expected bytes.
`timescale 1ns/1ns
module tb_top;
  localparam int POWER_UP_DELAY_TIMER = 50;
  logic clock, arst_n, external_reset_pin_n, oscillator_input_pin, brown_out_low;
  logic watchdog_timeout, sleeping, wake_irq, global_irq_enable, brown_out_enable;
  logic power_up_delay_enable, reg_wr, reg_rd, rd_d, supply_low, external_reset_pin_oe;
  logic core_reset_n, regs_load, pc_load, pc_next, watchdog_expired_n, sleep_entered_n;
  logic [1:0] osc_select;
  logic [3:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, dat;
  logic [12:0] pc_vector;
  logic [7:0] exp_q[$];
  int n_errors, checks, cycles, n;
  int seed = 32'h136feacd;
  rts_sequencer #(.POWER_UP_DELAY_TIMER_CYCLES(POWER_UP_DELAY_TIMER)) uut (.clock, .arst_n, .external_reset_pin_n,
    .oscillator_input_pin, .brown_out_low, .watchdog_timeout, .sleeping, .wake_irq,
    .global_irq_enable, .brown_out_enable, .power_up_delay_enable, .osc_select,
    .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .external_reset_pin_oe,
    .core_reset_n, .regs_load, .pc_load, .pc_next, .pc_vector, .watchdog_expired_n,
    .sleep_entered_n);
  rts_partner far (.clock, .supply_low, .oscillator_input_pin, .brown_out_low);
  // Free-running core clock.
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  task automatic conclude();
    $display("checks %0d errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic check(logic [15:0] got, logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cyc(int k);
    repeat (k) @(posedge clock);
  endtask
  // One bus cycle; a read leaves its expected byte for the scorer.
  task automatic bus(logic w, logic [3:0] a, logic [7:0] d);
    if (!w) exp_q.push_back(d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= w;
    reg_rd <= !w;
    cyc(1);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    cyc(1);
  endtask
  task automatic por(logic [1:0] osc, logic pde, logic boe);
    osc_select <= osc;
    power_up_delay_enable <= pde;
    brown_out_enable <= boe;
    arst_n <= 1'b0;
    cyc(2);
    arst_n <= 1'b1;
  endtask
  // Bounded wait so a core that never starts cannot hang the run.
  task automatic wait_up(int lo, int hi);
    n = 0;
    while (core_reset_n !== 1'b1 && n < 9000) begin
      cyc(1);
      n++;
    end
    check(16'(n >= lo && n <= hi), 16'h1);
  endtask
  // Retained-storage read data stand one cycle only, so every read is scored at the edge ending that cycle.
  always @(posedge clock) begin
    rd_d <= reg_rd;
    cycles++;
    if (rd_d) check(16'(reg_rdata), 16'(exp_q.pop_front()));
    if (cycles == 20000) begin
      n_errors++;
      conclude();
    end
  end
  initial begin
    {watchdog_timeout, sleeping, wake_irq, global_irq_enable, reg_wr, reg_rd} = '0;
    {supply_low, reg_addr, reg_wdata} = '0;
    external_reset_pin_n = 1'b1;
    por(rts_pkg::OSC_XT, 1'b0, 1'b1);
    wait_up(POWER_UP_DELAY_TIMER + 4090, POWER_UP_DELAY_TIMER + 4200);
    bus(1'b0, rts_pkg::OFF_POWER_STATUS, 8'h00);
    check({watchdog_expired_n, sleep_entered_n}, 16'h3);
    $display("test power-on done");
    bus(1'b1, rts_pkg::OFF_POWER_STATUS, 8'h03);
    bus(1'b0, rts_pkg::OFF_POWER_STATUS, 8'h03);
    bus(1'b0, 4'hf, 8'h00);
    dat = 8'($random(seed));
    bus(1'b1, 4'h4, dat);
    bus(1'b0, 4'h4, dat);
    $display("test registers done");
    supply_low <= 1'b1;
    cyc(10);
    supply_low <= 1'b0;
    cyc(20);
    supply_low <= 1'b1;
    cyc(3);
    supply_low <= 1'b0;
    wait_up(POWER_UP_DELAY_TIMER, POWER_UP_DELAY_TIMER + 10);
    bus(1'b0, rts_pkg::OFF_POWER_STATUS, 8'h02);
    bus(1'b0, 4'h4, dat);
    $display("test brown-out done");
    watchdog_timeout <= 1'b1;
    cyc(1);
    watchdog_timeout <= 1'b0;
    // The core reset is launched at the pulse edge, so it is looked at one edge later.
    cyc(1);
    check(16'(core_reset_n), 16'h0);
    wait_up(1, 3);
    check({watchdog_expired_n, sleep_entered_n}, 16'h1);
    bus(1'b0, rts_pkg::OFF_POWER_STATUS, 8'h02);
    bus(1'b0, rts_pkg::OFF_CAUSE, 8'h03);
    $display("test watchdog done");
    external_reset_pin_n <= 1'b0;
    cyc(1);
    external_reset_pin_n <= 1'b1;
    cyc(8);
    check(16'(core_reset_n), 16'h1);
    external_reset_pin_n <= 1'b0;
    cyc(10);
    check(16'(core_reset_n), 16'h0);
    external_reset_pin_n <= 1'b1;
    wait_up(4, 8);
    check({watchdog_expired_n, sleep_entered_n}, 16'h1);
    $display("test pin done");
    global_irq_enable <= 1'b1;
    sleeping <= 1'b1;
    cyc(4);
    wake_irq <= 1'b1;
    cyc(1);
    wake_irq <= 1'b0;
    n = 0;
    while (pc_load !== 1'b1 && n < 6000) begin
      cyc(1);
      n++;
    end
    check(16'(pc_vector), 16'(rts_pkg::VEC_IRQ));
    check(16'({pc_load, pc_next}), 16'h2);
    sleeping <= 1'b0;
    cyc(3);
    check({watchdog_expired_n, sleep_entered_n}, 16'h2);
    $display("test wake done");
    por(rts_pkg::OSC_RC, 1'b1, 1'b0);
    wait_up(2, 4);
    // Watchdog wake in resistor mode: no count, execution resumes in place.
    sleeping <= 1'b1;
    cyc(2);
    watchdog_timeout <= 1'b1;
    cyc(1);
    watchdog_timeout <= 1'b0;
    cyc(1);
    check(16'({core_reset_n, pc_load, pc_next}), 16'h5);
    check({watchdog_expired_n, sleep_entered_n}, 16'h0);
    sleeping <= 1'b0;
    supply_low <= 1'b1;
    cyc(6);
    check(16'(core_reset_n), 16'h1);
    supply_low <= 1'b0;
    bus(1'b0, rts_pkg::OFF_POWER_STATUS, 8'h00);
    $display("test rc mode done");
    external_reset_pin_n <= 1'b0;
    por(rts_pkg::OSC_XT, 1'b0, 1'b1);
    cyc(POWER_UP_DELAY_TIMER + 4200);
    check(16'(core_reset_n), 16'h0);
    external_reset_pin_n <= 1'b1;
    wait_up(4, 8);
    $display("test late pin done");
    conclude();
  end
endmodule
